// [hdl/vsq_pkg.sv]
// Types shared by the sequencer modules.
// Assumes the timing header is included where counts are needed.
package vsq_pkg;

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		VSQ_DISABLED = 3'b000,
		VSQ_CONFIG   = 3'b001,
		VSQ_MID_WAIT = 3'b010,
		VSQ_SOFT     = 3'b011,
		VSQ_REGULATE = 3'b100,
		VSQ_OV_RAMP  = 3'b101,
		VSQ_LATCHED  = 3'b110
	} vsq_state_t;

	// Per-phase drive level
	typedef enum logic [1:0]
	{
		VSQ_PWM_OPEN = 2'b00,
		VSQ_PWM_MID  = 2'b01,
		VSQ_PWM_LOW  = 2'b10,
		VSQ_PWM_HIGH = 2'b11
	} vsq_pwm_t;

endpackage

// [hdl/vsq_regs.svh]
// Timing counts and codes for the start-up and fault sequencer.
// Assumes a 10 MHz core clock; included by the sequencer module only.
`ifndef VSQ_REGS_SVH
`define VSQ_REGS_SVH

`define VSQ_CLK_NS          100
`define VSQ_OCP_DELAY_NS    50000
`define VSQ_OCP_CYCLES      ((`VSQ_OCP_DELAY_NS) / (`VSQ_CLK_NS))
`define VSQ_CFG_CYCLES      16
`define VSQ_MID_CYCLES      8
`define VSQ_SS_STEP_CYCLES  4
`define VSQ_DAC_W           8
`define VSQ_OCP_W           10
`define VSQ_TMR_W           8

`endif

// [hdl/vsq_sequencer.sv]
// Start-up and protection sequencer for a multiphase regulator.
// Assumes comparator flags are analog levels, enable acts as fault clear.
//
// Operation
// - Logic supply or ramp supply undervoltage blocks operation.
// - Driver-enable low: all phases to mid level, soft start restarts.
// - After enable, outputs open with test current; gather configuration.
// - After configuration every phase goes to mid level (diode mode).
// - After mid level, assert driver-enable, then release error amplifier.
// - Soft start steps reference code from zero to target at fixed rate.
// - Each phase leaves mid level at its first pulse, on overvoltage (low) or when disabled (open).
// - Total current limit scales with active phase count.
// - During soft start a per-phase current limit also applies.
// - Lower overcurrent threshold starts latch-off counter; trips on expiry.
// - Upper overcurrent threshold shuts down at once.
// - Overcurrent and overvoltage latch until enable is cycled.
// - Undervoltage below reference minus droop drops regulator ready.
// - Relative overvoltage forces all phases low; they stay low until enable is cycled.
// - After first overvoltage trip reference ramps down to zero.
// - At zero after overvoltage, phases low, driver-enable stays high.
// - During soft start a fixed absolute overvoltage threshold is used.
// - Fourth phase pin high at configuration selects three phases.
// - Ramp supply lockout is honoured only while enabled.
`timescale 1ns/1ps
`include "vsq_regs.svh"
module vsq_sequencer
#(
	parameter int PHASES = 4,
	parameter int DAC_W  = `VSQ_DAC_W
)
(
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic                enable,
	input  wire logic                vcc_ok_raw,
	input  wire logic                ramp_ok_raw,
	input  wire logic                driver_enable_line_in,
	input  wire logic                ocp_low_raw,
	input  wire logic                ocp_high_raw,
	input  wire logic                phase_ocp_raw,
	input  wire logic                under_v_raw,
	input  wire logic                over_rel_raw,
	input  wire logic                over_abs_raw,
	input  wire logic                fourth_phase_output_in,
	input  wire logic [DAC_W-1:0]    target_code,
	input  wire logic [PHASES-1:0]   pwm_pulse,
	input  wire logic [PHASES-1:0]   pwm_shed,
	output vsq_pkg::vsq_pwm_t        pwm_state [PHASES],
	output logic                     test_current_on,
	output logic                     driver_enable_line_out,
	output logic                     driver_enable_line_oe,
	output logic                     comp_release,
	output logic [DAC_W-1:0]         ref_code,
	output logic                     regulator_ready_out,
	output logic                     three_phase,
	output logic [2:0]               active_phases,
	output logic                     phase_limit_on,
	output logic                     fault_latched
);
	import vsq_pkg::*;

	vsq_sync_if s ();

	vsq_sync u_sync
	(
		.clk     (clk),
		.reset_n (reset_n),
		.raw     ({fourth_phase_output_in, over_abs_raw, over_rel_raw,
			under_v_raw, ocp_high_raw | (phase_ocp_raw & phase_limit_on),
			ocp_low_raw, driver_enable_line_in, ramp_ok_raw,
			vcc_ok_raw}),
		.o       (s)
	);

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	vsq_state_t                 state;
	vsq_state_t                 next_state;
	logic [`VSQ_TMR_W-1:0]      tmr;
	logic [`VSQ_TMR_W-1:0]      next_tmr;
	logic [`VSQ_OCP_W-1:0]      ocp_cnt;
	logic [`VSQ_OCP_W-1:0]      next_ocp_cnt;
	logic [DAC_W-1:0]           next_ref_code;
	logic                       next_three_phase;
	logic                       next_fault_latched;
	logic                       next_comp_release;
	logic                       next_test_current_on;
	logic                       next_drv_out;
	logic                       next_drv_oe;
	logic                       next_ready;
	logic                       next_phase_limit_on;
	logic [2:0]                 next_active;
	logic                       ovp_seen;
	logic                       next_ovp_seen;
	vsq_pwm_t                   next_pwm [PHASES];
	logic                       supply_ok;
	logic                       ocp_trip;
	logic                       ovp_now;
	logic                       started;

	// Count set bits of the phase enable mask
	function automatic logic [2:0] count_ones(input logic [PHASES-1:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < PHASES; i++)
			n = n + {2'h0, v[i]};
		return n;
	endfunction

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		// Ramp lockout ignored while disabled; vcc always watched
		started   = (state != VSQ_DISABLED);
		supply_ok = s.vcc_ok & (s.ramp_ok | ~started);
		ocp_trip  = s.ocp_high |
			(s.ocp_low && ocp_cnt == `VSQ_OCP_W'(`VSQ_OCP_CYCLES - 1));
		ovp_now   = (state == VSQ_SOFT) ? s.over_abs : s.over_rel;

		next_state           = state;
		next_tmr             = tmr;
		next_ocp_cnt         = 10'h000;
		next_ref_code        = ref_code;
		next_three_phase     = three_phase;
		next_fault_latched   = fault_latched;
		next_comp_release    = comp_release;
		next_test_current_on = 1'b0;
		next_drv_out         = 1'b0;
		next_drv_oe          = 1'b0;
		next_ready           = regulator_ready_out;
		next_phase_limit_on  = 1'b0;
		next_ovp_seen        = ovp_seen;
		next_active          = three_phase ? 3'h3 : 3'h4;
		for (int i = 0; i < PHASES; i++)
			next_pwm[i] = pwm_state[i];

		// Lower threshold counts, any clear restarts the count
		if (s.ocp_low && (state == VSQ_SOFT || state == VSQ_REGULATE))
			next_ocp_cnt = ocp_cnt + 10'h001;

		case (state)
		VSQ_DISABLED:
		begin
			next_ref_code      = '0;
			next_comp_release  = 1'b0;
			next_ready         = 1'b0;
			next_fault_latched = 1'b0;
			next_ovp_seen      = 1'b0;
			for (int i = 0; i < PHASES; i++)
				next_pwm[i] = VSQ_PWM_OPEN;
			if (enable && supply_ok)
			begin
				next_state = VSQ_CONFIG;
				next_tmr   = '0;
			end
		end
		VSQ_CONFIG:
		begin
			next_test_current_on = 1'b1;
			next_tmr = tmr + 8'h01;
			if (tmr == `VSQ_TMR_W'(`VSQ_CFG_CYCLES - 1))
			begin
				next_three_phase = s.cfg_three;
				for (int i = 0; i < PHASES; i++)
					next_pwm[i] = VSQ_PWM_MID;
				next_state = VSQ_MID_WAIT;
				next_tmr   = '0;
			end
		end
		VSQ_MID_WAIT:
		begin
			next_drv_out = 1'b1;
			next_drv_oe  = 1'b1;
			next_tmr     = tmr + 8'h01;
			if (tmr == `VSQ_TMR_W'(`VSQ_MID_CYCLES - 1))
			begin
				next_comp_release = 1'b1;
				next_state = VSQ_SOFT;
				next_tmr   = '0;
			end
		end
		VSQ_SOFT:
		begin
			next_drv_out        = 1'b1;
			next_drv_oe         = 1'b1;
			next_phase_limit_on = 1'b1;
			next_tmr = tmr + 8'h01;
			if (tmr == `VSQ_TMR_W'(`VSQ_SS_STEP_CYCLES - 1))
			begin
				next_tmr = '0;
				if (ref_code < target_code)
					next_ref_code = ref_code + DAC_W'(1);
			end
			for (int i = 0; i < PHASES; i++)
				if (pwm_state[i] == VSQ_PWM_MID && pwm_pulse[i])
					next_pwm[i] = VSQ_PWM_HIGH;
			if (ref_code == target_code)
			begin
				next_state          = VSQ_REGULATE;
				next_ready          = 1'b1;
				next_phase_limit_on = 1'b0;
			end
		end
		VSQ_REGULATE:
		begin
			next_drv_out = 1'b1;
			next_drv_oe  = 1'b1;
			next_ready   = ~s.under_v;
			next_ref_code = target_code;
			// Shed phases lower the total limit proportionally
			next_active = count_ones(~pwm_shed);
			for (int i = 0; i < PHASES; i++)
				if (ovp_now)
					next_pwm[i] = VSQ_PWM_LOW;
				else if (pwm_state[i] == VSQ_PWM_MID)
					next_pwm[i] = pwm_pulse[i] ? VSQ_PWM_HIGH
						: VSQ_PWM_MID;
				else
					next_pwm[i] = pwm_pulse[i] ? VSQ_PWM_HIGH
						: VSQ_PWM_LOW;
		end
		VSQ_OV_RAMP:
		begin
			next_drv_out = 1'b1;
			next_drv_oe  = 1'b1;
			next_ready   = 1'b0;
			next_tmr = tmr + 8'h01;
			for (int i = 0; i < PHASES; i++)
				next_pwm[i] = VSQ_PWM_LOW;
			if (tmr == `VSQ_TMR_W'(`VSQ_SS_STEP_CYCLES - 1))
			begin
				next_tmr = '0;
				if (ref_code != '0)
					next_ref_code = ref_code - DAC_W'(1);
			end
			if (ref_code == '0)
				next_state = VSQ_LATCHED;
		end
		VSQ_LATCHED:
		begin
			// Drivers stay enabled after overvoltage to clamp output
			next_drv_out = ovp_seen;
			next_drv_oe  = ovp_seen;
			next_ready   = 1'b0;
			for (int i = 0; i < PHASES; i++)
				next_pwm[i] = ovp_seen ? VSQ_PWM_LOW : VSQ_PWM_MID;
		end
		default:
			next_state = VSQ_DISABLED;
		endcase

		// Faults, in priority order
		if (state == VSQ_SOFT || state == VSQ_REGULATE)
		begin
			if (ocp_trip)
			begin
				next_state         = VSQ_LATCHED;
				next_fault_latched = 1'b1;
				next_comp_release  = 1'b0;
				next_ready         = 1'b0;
			end
			else if (ovp_now && !ovp_seen)
			begin
				next_state         = VSQ_OV_RAMP;
				next_ovp_seen      = 1'b1;
				next_fault_latched = 1'b1;
				next_ready         = 1'b0;
				next_tmr           = '0;
			end
			else if (!s.drv_ready)
			begin
				// Driver not ready: back to mid level, restart ramp
				next_state    = VSQ_MID_WAIT;
				next_ref_code = '0;
				next_comp_release = 1'b0;
				next_ready    = 1'b0;
				next_tmr      = '0;
				for (int i = 0; i < PHASES; i++)
					next_pwm[i] = VSQ_PWM_MID;
			end
		end

		// A latched fault outlives a supply dip; only enable clears it
		if (started && !supply_ok && !next_fault_latched)
			next_state = VSQ_DISABLED;
		if (!enable)
			next_state = VSQ_DISABLED;
	end

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state                  <= VSQ_DISABLED;
			tmr                    <= '0;
			ocp_cnt                <= '0;
			ref_code               <= '0;
			three_phase            <= 1'b0;
			fault_latched          <= 1'b0;
			comp_release           <= 1'b0;
			test_current_on        <= 1'b0;
			driver_enable_line_out <= 1'b0;
			driver_enable_line_oe  <= 1'b0;
			regulator_ready_out    <= 1'b0;
			phase_limit_on         <= 1'b0;
			active_phases          <= 3'h4;
			ovp_seen               <= 1'b0;
			for (int i = 0; i < PHASES; i++)
				pwm_state[i] <= VSQ_PWM_OPEN;
		end
		else
		begin
			state                  <= next_state;
			tmr                    <= next_tmr;
			ocp_cnt                <= next_ocp_cnt;
			ref_code               <= next_ref_code;
			three_phase            <= next_three_phase;
			fault_latched          <= next_fault_latched;
			comp_release           <= next_comp_release;
			test_current_on        <= next_test_current_on;
			driver_enable_line_out <= next_drv_out;
			driver_enable_line_oe  <= next_drv_oe;
			regulator_ready_out    <= next_ready;
			phase_limit_on         <= next_phase_limit_on;
			active_phases          <= next_active;
			ovp_seen               <= next_ovp_seen;
			for (int i = 0; i < PHASES; i++)
				pwm_state[i] <= next_pwm[i];
		end
	end
endmodule

// [hdl/vsq_sync.sv]
// Two-flop synchronisers for the analog comparator results.
// Assumes comparators settle slower than two clock periods.
`timescale 1ns/1ps
module vsq_sync
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [8:0] raw,
	vsq_sync_if.src         o
);
	import vsq_pkg::*;

	logic [8:0] stage1;
	logic [8:0] stage2;
	logic [8:0] next_stage1;
	logic [8:0] next_stage2;

	// ------------------------------------------------------------
	// First stage feeds only the second stage
	// ------------------------------------------------------------
	always_comb
	begin
		next_stage1 = raw;
		next_stage2 = stage1;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			stage1 <= 9'h000;
			stage2 <= 9'h000;
		end
		else
		begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
		end
	end

	assign o.vcc_ok    = stage2[0];
	assign o.ramp_ok   = stage2[1];
	assign o.drv_ready = stage2[2];
	assign o.ocp_low   = stage2[3];
	assign o.ocp_high  = stage2[4];
	assign o.under_v   = stage2[5];
	assign o.over_rel  = stage2[6];
	assign o.over_abs  = stage2[7];
	assign o.cfg_three = stage2[8];
endmodule

// [hdl/vsq_sync_if.sv]
// Bundle of synchronised fault flags between synchroniser and sequencer.
// Assumes one clock domain.
`timescale 1ns/1ps
interface vsq_sync_if;
	logic vcc_ok;
	logic ramp_ok;
	logic drv_ready;
	logic ocp_low;
	logic ocp_high;
	logic under_v;
	logic over_rel;
	logic over_abs;
	logic cfg_three;
	modport src (output vcc_ok, ramp_ok, drv_ready, ocp_low, ocp_high,
		under_v, over_rel, over_abs, cfg_three);
	modport dst (input vcc_ok, ramp_ok, drv_ready, ocp_low, ocp_high,
		under_v, over_rel, over_abs, cfg_three);
endinterface

// [verification/testbench.sv]
// Self-checking bench for the start-up and fault sequencer.
// Assumes a 10 MHz clock and the gate driver model on the enable wire.
`timescale 1ns/1ps
module testbench;
	import vsq_pkg::*;
	logic clk = 0, reset_n = 0, en = 0, vcc = 1, rmp = 1, ocl = 0;
	logic och = 0, pocp = 0, uv = 0, ovr = 0, ova = 0, p4 = 0, uvq = 0;
	logic [7:0] tgt = 8'h10, ref_code, last = 0;
	logic [3:0] pulse = 4'h0, shed = 4'h0;
	logic [2:0] ap;
	vsq_pwm_t pwm [4];
	logic tc, dout, doe, rel, rdy, tp, plim, flt, line;
	logic [7:0] rq[$];
	int tq[$], cyc = 0, err_count = 0, compares = 0;

	initial forever #50 clk = ~clk;

	vsq_sequencer u_dut
	(
		.clk, .reset_n, .enable(en), .vcc_ok_raw(vcc), .ramp_ok_raw(rmp),
		.driver_enable_line_in(line), .ocp_low_raw(ocl), .ocp_high_raw(och),
		.phase_ocp_raw(pocp), .under_v_raw(uv), .over_rel_raw(ovr),
		.over_abs_raw(ova), .fourth_phase_output_in(p4), .target_code(tgt),
		.pwm_pulse(pulse), .pwm_shed(shed), .pwm_state(pwm),
		.test_current_on(tc), .driver_enable_line_out(dout),
		.driver_enable_line_oe(doe), .comp_release(rel), .ref_code(ref_code),
		.regulator_ready_out(rdy), .three_phase(tp), .active_phases(ap),
		.phase_limit_on(plim), .fault_latched(flt)
	);

	vsq_drv_model u_drv
	(
		.clk, .uv_req(uvq), .drv_out(dout), .drv_oe(doe), .line(line)
	);

	// Reference history: the start task and the overvoltage test compare against it
	always @(posedge clk)
	begin
		cyc++;
		if (ref_code !== last)
		begin
			rq.push_back(ref_code);
			tq.push_back(cyc);
		end
		last = ref_code;
	end

	task chk(input logic [31:0] seen, exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wfor(ref logic s, input logic v);
		for (int i = 0; i < 2000 && s !== v; i++)
			tick(1);
		chk(s, v, "wait");
	endtask

	task automatic start(input logic f4, input logic full);
		en = 0;
		p4 = f4;
		pulse = 4'h0;
		tick(6);
		// Target moves only once disabled, so the ramp never jumps
		tgt = 8'h08 + 8'($urandom % 24);
		rq = {};
		tq = {};
		en = 1;
		wfor(tc, 1);
		chk(flt, 0, "clear");
		chk(pwm[3], VSQ_PWM_OPEN, "open");
		wfor(tc, 0);
		chk(pwm[0], VSQ_PWM_MID, "mid");
		chk(tp, f4, "count");
		wfor(rel, 1);
		tick(2);
		chk(plim, 1, "plim");
		if (!full)
			return;
		wfor(rdy, 1);
		chk(ref_code, tgt, "target");
		chk(plim, 0, "plim off");
		foreach (rq[i])
		begin
			chk(rq[i], i + 1, "step");
			if (i > 0)
				chk(tq[i] - tq[i-1], 4, "rate");
		end
	endtask

	task tally_and_finish;
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'hF05D));
		tick(8);
		chk(pwm[0], VSQ_PWM_OPEN, "rst pwm");
		chk(ap, 3'h4, "rst phases");
		chk({doe, rel, flt, rdy}, 4'h0, "rst out");
		reset_n = 1;
		$display("test reset done");
		start(0, 1);
		pulse = 4'h1;
		tick(5);
		chk(pwm[0], VSQ_PWM_HIGH, "fired");
		chk(pwm[1], VSQ_PWM_MID, "held");
		shed = 4'($urandom) & 4'h7;
		tick(5);
		chk(ap, 4 - $countones(shed), "shed");
		shed = 4'h0;
		pocp = 1;
		tick(6);
		chk(flt, 0, "phase limit");
		pocp = 0;
		$display("test startup done");
		uvq = 1;
		tick(6);
		foreach (pwm[i])
			chk(pwm[i], VSQ_PWM_MID, "drv mid");
		chk(ref_code, 8'h00, "drv ref");
		uvq = 0;
		wfor(rdy, 1);
		chk(ref_code, tgt, "restart");
		uv = 1;
		tick(5);
		chk(rdy, 0, "uv ready");
		uv = 0;
		och = 1;
		tick(5);
		chk(flt, 1, "instant");
		och = 0;
		$display("test restart done");
		start(0, 1);
		ocl = 1;
		tick(300);
		ocl = 0;
		tick(5);
		ocl = 1;
		tick(490);
		chk(flt, 0, "early");
		tick(20);
		chk(flt, 1, "late");
		ocl = 0;
		tick(10);
		chk(flt, 1, "hold");
		$display("test overcurrent done");
		start(1, 1);
		rq = {};
		ovr = 1;
		tick(5);
		chk(pwm[0], VSQ_PWM_LOW, "ov low");
		tick(400);
		chk(ref_code, 8'h00, "ramp end");
		chk({doe, dout}, 2'h3, "drv kept");
		foreach (rq[i])
			chk(rq[i], tgt - 1 - i, "ramp");
		ovr = 0;
		tick(10);
		chk(pwm[0], VSQ_PWM_LOW, "ov latch");
		$display("test overvoltage done");
		start(0, 0);
		ovr = 1;
		tick(5);
		chk(pwm[0], VSQ_PWM_MID, "rel ignored");
		ovr = 0;
		ova = 1;
		tick(5);
		chk(pwm[0], VSQ_PWM_LOW, "abs ov");
		ova = 0;
		start(0, 0);
		pocp = 1;
		tick(5);
		chk(flt, 1, "phase limit trip");
		pocp = 0;
		$display("test soft start ov done");
		for (int k = 0; k < 2; k++)
		begin
			start(0, 1);
			{vcc, rmp} = k ? 2'b01 : 2'b10;
			tick(6);
			chk(rel, 0, "supply uv");
			{vcc, rmp} = 2'b11;
		end
		en = 0;
		tick(6);
		rmp = 0;
		en = 1;
		tick(40);
		chk(doe, 0, "ramp lockout");
		rmp = 1;
		$display("test supplies done");
		tick(4);
		reset_n = 0;
		tick(2);
		chk({tc, doe, rel, flt, rdy}, 5'h00, "mid reset");
		chk(pwm[0], VSQ_PWM_OPEN, "mid reset pwm");
		reset_n = 1;
		tick(10);
		chk(tc, 1, "config after reset");
		en = 0;
		tick(4);
		$display("test mid reset done");
		tally_and_finish();
	end

	initial
	begin
		tick(20000);
		err_count++;
		tally_and_finish();
	end
endmodule

// [verification/vsq_drv_model.sv]
// Gate driver model on the shared driver-enable wire.
// Assumes drivers pull the wire low; controller only drives it high.
`timescale 1ns/1ps
module vsq_drv_model
#(
	parameter int HOLD = 40
)
(
	input  wire logic clk,
	input  wire logic uv_req,
	input  wire logic drv_out,
	input  wire logic drv_oe,
	output logic      line
);
	int hold_cnt = 0;
	// Low hold outlasts the bad supply so a restart can happen
	always @(posedge clk)
		if (uv_req)
			hold_cnt <= HOLD;
		else if (hold_cnt > 0)
			hold_cnt <= hold_cnt - 1;
	// Undriven wire rests low, never at the last value
	assign line = drv_oe & drv_out & !uv_req & (hold_cnt == 0);
endmodule

// [verification/vsq_seq_monitor.sv]
// Port-level checks on the start-up and fault sequencer.
// Assumes one clock; bound onto every sequencer instance.
`timescale 1ns/1ps
module vsq_seq_monitor
	import vsq_pkg::*;
#(
	parameter int PHASES = 4,
	parameter int DAC_W  = 8
)
(
	input wire logic               clk,
	input wire logic               reset_n,
	input wire logic               enable,
	input wire logic               driver_enable_line_in,
	input wire logic               ocp_high_raw,
	input wire logic               under_v_raw,
	input wire logic               over_rel_raw,
	input wire logic [DAC_W-1:0]   target_code,
	input wire vsq_pkg::vsq_pwm_t  pwm_state [PHASES],
	input wire logic               driver_enable_line_out,
	input wire logic               driver_enable_line_oe,
	input wire logic               comp_release,
	input wire logic [DAC_W-1:0]   ref_code,
	input wire logic               regulator_ready_out,
	input wire logic               fault_latched
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_ref_step: assert property (
		ref_code > $past(ref_code) |-> ref_code == $past(ref_code) + 1'b1)
		else $error("reference jumped");
	chk_ref_ceiling: assert property (
		comp_release && !fault_latched |-> ref_code <= target_code)
		else $error("reference above target");
	chk_ocp_instant: assert property (
		comp_release && ocp_high_raw && enable |-> ##[1:4] fault_latched)
		else $error("no immediate trip");
	chk_latch_hold: assert property (
		fault_latched && enable |=> fault_latched)
		else $error("latch lost");
	chk_drv_at_mid: assert property (
		$rose(driver_enable_line_oe) |-> pwm_state[0] == VSQ_PWM_MID)
		else $error("driver on before mid");
	chk_release_drv: assert property (
		$rose(comp_release) |->
		driver_enable_line_oe && driver_enable_line_out)
		else $error("release before driver on");
	chk_drv_restart: assert property (
		comp_release && !driver_enable_line_in && !fault_latched && enable
		|-> ##[1:4] (pwm_state[0] == VSQ_PWM_MID && ref_code == 0))
		else $error("no restart on driver low");
	chk_ov_low: assert property (
		regulator_ready_out && over_rel_raw && enable
		|-> ##[1:4] pwm_state[0] == VSQ_PWM_LOW)
		else $error("phases not low on overvoltage");
	chk_uv_ready: assert property (
		regulator_ready_out && under_v_raw |-> ##[1:4] !regulator_ready_out)
		else $error("ready kept on undervoltage");
	chk_off_idle: assert property (
		!enable [*4] |=>
		!driver_enable_line_oe && !comp_release && ref_code == 0)
		else $error("not idle when disabled");
	cover property ($rose(regulator_ready_out));
	cover property ($rose(fault_latched));
	cover property ($fell(comp_release) && enable);
endmodule

bind vsq_sequencer vsq_seq_monitor #(.PHASES(PHASES), .DAC_W(DAC_W)) u_mon
(
	.clk, .reset_n, .enable, .driver_enable_line_in, .ocp_high_raw,
	.under_v_raw, .over_rel_raw, .target_code, .pwm_state,
	.driver_enable_line_out, .driver_enable_line_oe, .comp_release,
	.ref_code, .regulator_ready_out, .fault_latched
);
